// ---- rtl/cse_pkg.sv ----
package cse_pkg;
	// Counter operating modes
	typedef enum logic [1:0] {
		MODE_EDGE  = 2'b00,
		MODE_TRAIN = 2'b01,
		MODE_ETS   = 2'b10
	} cse_mode_type;

	// Sequencing phase of a generated pulse
	typedef enum logic [1:0] {
		PH_IDLE  = 2'b00,
		PH_DELAY = 2'b01,
		PH_WIDTH = 2'b10
	} cse_phase_type;

	localparam int unsigned CNT_W   = 32;
	localparam int unsigned INCR_W  = 8;
	localparam int unsigned EXT_W   = 24;
	localparam int unsigned SYNC_STAGES = 2;

	// Register offsets
	localparam logic [7:0] OFF_CTRL       = 8'h00;
	localparam logic [7:0] OFF_CMD        = 8'h04;
	localparam logic [7:0] OFF_SEL        = 8'h08;
	localparam logic [7:0] OFF_ENC        = 8'h0C;
	localparam logic [7:0] OFF_DELAY      = 8'h10;
	localparam logic [7:0] OFF_WIDTH_HI   = 8'h14;
	localparam logic [7:0] OFF_WIDTH_LO   = 8'h18;
	localparam logic [7:0] OFF_INCR       = 8'h1C;
	localparam logic [7:0] OFF_COUNT      = 8'h20;
	localparam logic [7:0] OFF_STATUS     = 8'h24;
	localparam logic [7:0] OFF_PIO_ROUTE  = 8'h80;
	localparam logic [7:0] OFF_TRIG_ROUTE = 8'h84;

	// Control and route field positions
	localparam int unsigned CTRL_SRC_FALL  = 2;
	localparam int unsigned CTRL_GATE_FALL = 3;
	localparam int unsigned CTRL_TOGGLE    = 4;
	localparam int unsigned CTRL_INVERT    = 5;
	localparam int unsigned CTRL_DIR_B     = 6;
	localparam int unsigned CTRL_HWARM_EN  = 7;
	localparam int unsigned ROUTE_EN       = 3;

	// Write masks and reset values
	localparam logic [31:0] SEL_WMASK = 32'h1F1F_1F1F;
	localparam logic [31:0] ENC_WMASK = 32'h001F_1F1F;
	localparam logic [31:0] RST_REG   = 32'h0000_0000;

	// Legal choices of each selector, one bit per selector code
	localparam logic [31:0] MASK_SRC  = 32'h0307_FFFF;
	localparam logic [31:0] MASK_GATE = 32'h0CFD_FFF8;
	localparam logic [31:0] MASK_AUX  = 32'h1E1D_FFF8;
	localparam logic [31:0] MASK_ARM  = 32'h041D_FFF8;
	localparam logic [31:0] MASK_ENC  = 32'h0005_FFF8;
endpackage : cse_pkg

// ---- rtl/cse_sel_mux.sv ----
`timescale 1ns/1ps
module cse_sel_mux #(
	parameter logic [31:0] MASK = 32'h0000_0000
) (
	// Candidates and choice
	input  wire logic [31:0] vec,
	input  wire logic [4:0]  sel,
	// Chosen level
	output logic             lvl
);
	// Codes outside the mask give a quiet low instead of a stray signal
	assign lvl = MASK[sel] & vec[sel];
endmodule : cse_sel_mux

// ---- rtl/cse_counter.sv ----
`timescale 1ns/1ps
module cse_counter #(
	parameter int unsigned CNT_W  = 32,
	parameter int unsigned INCR_W = 8
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rst,
	// Selected signals
	input  wire logic                src_lvl,
	input  wire logic                gate_lvl,
	input  wire logic                dir_lvl,
	input  wire logic                hardware_arm_input_lvl,
	// Control
	input  wire logic                arm_cmd,
	input  wire logic                disarm_cmd,
	input  wire logic                hardware_arm_input_en,
	input  wire cse_pkg::cse_mode_type mode,
	input  wire logic                src_fall,
	input  wire logic                gate_fall,
	input  wire logic                out_toggle,
	input  wire logic                dir_from_b,
	input  wire logic [CNT_W-1:0]    delay,
	input  wire logic [CNT_W-1:0]    width_hi,
	input  wire logic [CNT_W-1:0]    width_lo,
	input  wire logic [INCR_W-1:0]   incr,
	// State
	output logic [CNT_W-1:0]         count_q,
	output logic                     armed_q,
	output logic                     out_lvl_q,
	output logic                     tc
);
	logic                  src_prev_q;
	logic                  gate_prev_q;
	logic                  arm_prev_q;
	logic                  train_hi_q;
	logic [CNT_W-1:0]      cur_delay_q;
	cse_pkg::cse_phase_type phase_q;
	logic                  src_evt;
	logic                  gate_evt;
	logic                  arm_go;
	logic                  arm_start;
	logic                  tc_evt;

	function automatic logic [CNT_W-1:0] dec1(input logic [CNT_W-1:0] v);
		dec1 = (v == '0) ? '0 : v - 1'b1;
	endfunction : dec1

	assign src_evt   = src_fall ? (src_prev_q & ~src_lvl) : (~src_prev_q & src_lvl);
	assign gate_evt  = gate_fall ? (gate_prev_q & ~gate_lvl) : (~gate_prev_q & gate_lvl);
	assign arm_go    = arm_cmd | (hardware_arm_input_en & hardware_arm_input_lvl & ~arm_prev_q);
	assign arm_start = arm_go & ~armed_q;
	assign tc        = armed_q & (count_q == '0);
	assign tc_evt    = armed_q & src_evt & (count_q == '0) &
		((mode == cse_pkg::MODE_TRAIN) | ((mode == cse_pkg::MODE_ETS) & (phase_q != cse_pkg::PH_IDLE)));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			src_prev_q  <= 1'b0;
			gate_prev_q <= 1'b0;
			arm_prev_q  <= 1'b0;
		end else begin
			src_prev_q  <= src_lvl;
			gate_prev_q <= gate_lvl;
			arm_prev_q  <= hardware_arm_input_lvl;
		end
	end

	// Arm beats a disarm in the same cycle so a trigger is never lost
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			armed_q <= 1'b0;
		end else if (arm_go) begin
			armed_q <= 1'b1;
		end else if (disarm_cmd) begin
			armed_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_q     <= '0;
			phase_q     <= cse_pkg::PH_IDLE;
			train_hi_q  <= 1'b0;
			cur_delay_q <= '0;
		end else if (arm_start) begin
			cur_delay_q <= delay;
			train_hi_q  <= 1'b0;
			count_q     <= (mode == cse_pkg::MODE_TRAIN) ? dec1(delay) : '0;
			phase_q     <= (mode == cse_pkg::MODE_TRAIN) ? cse_pkg::PH_DELAY : cse_pkg::PH_IDLE;
		end else if (!armed_q) begin
			phase_q <= cse_pkg::PH_IDLE;
		end else begin
			case (mode)
				cse_pkg::MODE_EDGE: begin
					if (src_evt) begin
						count_q <= (!dir_from_b || dir_lvl) ? count_q + 1'b1 : count_q - 1'b1;
					end
				end
				cse_pkg::MODE_TRAIN: begin
					if (src_evt) begin
						if (count_q == '0) begin
							count_q    <= dec1(train_hi_q ? width_lo : width_hi);
							train_hi_q <= ~train_hi_q;
						end else begin
							count_q <= count_q - 1'b1;
						end
					end
				end
				cse_pkg::MODE_ETS: begin
					case (phase_q)
						cse_pkg::PH_IDLE: begin
							if (gate_evt) begin
								count_q <= dec1(cur_delay_q);
								phase_q <= cse_pkg::PH_DELAY;
							end
						end
						cse_pkg::PH_DELAY: begin
							if (src_evt) begin
								count_q <= (count_q == '0) ? dec1(width_hi) : count_q - 1'b1;
								phase_q <= (count_q == '0) ? cse_pkg::PH_WIDTH : cse_pkg::PH_DELAY;
							end
						end
						cse_pkg::PH_WIDTH: begin
							if (src_evt) begin
								if (count_q == '0) begin
									phase_q     <= cse_pkg::PH_IDLE;
									cur_delay_q <= cur_delay_q + CNT_W'(incr);
								end else begin
									count_q <= count_q - 1'b1;
								end
							end
						end
						default: begin
							phase_q <= cse_pkg::PH_IDLE;
						end
					endcase
				end
				default: begin
					count_q <= count_q;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_lvl_q <= 1'b0;
		end else if (!armed_q) begin
			out_lvl_q <= 1'b0;
		end else if (tc_evt) begin
			out_lvl_q <= out_toggle ? ~out_lvl_q : 1'b1;
		end else if (!out_toggle) begin
			out_lvl_q <= 1'b0;
		end
	end
endmodule : cse_counter

// ---- rtl/cse_routing.sv ----
`timescale 1ns/1ps
// Functional notes
// - Each counter holds a 32-bit count
// - EQUIVALENT_TIME_SAMPLING_MODE: pulse after delay, delay grows each
// - EQUIVALENT_TIME_SAMPLING_MODE delay increment spans 0 to 255
// - EQUIVALENT_TIME_SAMPLING_MODE ignores gate edges during pulse
// - EQUIVALENT_TIME_SAMPLING_MODE sequence repeats until counter disarmed
// - Frequency division is continuous pulse train
// - Count changes on selected source edge
// - Source selector: timebases, triggers, terminals, backplane
// - Source may take other counter's flag, gate
// - Source and gate routable out; outputs start off
// - Gate selector choices plus other counter's signals
// - Auxiliary input selected from listed trigger sources
// - Auxiliary also takes cross and own gate
// - Phase B input sets count direction
// - Separate phase A, B, Z selectors
// - Nothing runs until counter is armed
// - Arm by software or hardware arm input
// - Hardware arm selector choices incl. other output
// - Terminal count flag when armed and count is zero
// - Output pulses or toggles, polarity selectable
// - Delays and widths counted in source edges
module cse_routing (
	// Clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Timebases
	input  wire logic        TIMEBASE_80M,
	input  wire logic        TIMEBASE_20M,
	input  wire logic        TIMEBASE_100K,
	// Trigger lines, terminals and backplane
	input  wire logic [7:0]  SYSTEM_TRIGGER_LINE_IN,
	output logic      [7:0]  SYSTEM_TRIGGER_LINE_OUT,
	output logic      [7:0]  SYSTEM_TRIGGER_LINE_OE,
	input  wire logic [5:0]  PROGRAMMABLE_IO_TERMINAL_IN,
	output logic      [3:0]  PROGRAMMABLE_IO_TERMINAL_OUT,
	output logic      [3:0]  PROGRAMMABLE_IO_TERMINAL_OE,
	input  wire logic        BACKPLANE_REFERENCE_CLOCK,
	input  wire logic        BACKPLANE_STAR_TRIGGER,
	// Acquisition and generation timing
	input  wire logic        ACQUISITION_REFERENCE_TRIGGER,
	input  wire logic        ACQUISITION_START_TRIGGER,
	input  wire logic        ACQUISITION_SAMPLE_CLOCK,
	input  wire logic        ACQUISITION_CONVERT_CLOCK,
	input  wire logic        GENERATION_SAMPLE_CLOCK,
	// Counter state
	output logic      [1:0]  COUNTER_OUT,
	output logic      [1:0]  TERMINAL_COUNT_FLAG
);
	localparam int unsigned NCTR = 2;

	logic [cse_pkg::EXT_W-1:0] ext_raw;
	logic [cse_pkg::EXT_W-1:0] sync1_q;
	logic [cse_pkg::EXT_W-1:0] sync2_q;

	logic [7:0]          ctrl_q      [NCTR];
	logic [31:0]         sel_q       [NCTR];
	logic [31:0]         enc_q       [NCTR];
	logic [31:0]         delay_q     [NCTR];
	logic [31:0]         whi_q       [NCTR];
	logic [31:0]         wlo_q       [NCTR];
	logic [7:0]          incr_q      [NCTR];
	logic                arm_cmd_q   [NCTR];
	logic                disarm_cmd_q[NCTR];
	logic [15:0]         pio_route_q;
	logic [31:0]         trig_route_q;

	logic [31:0]         vec         [NCTR];
	logic [NCTR-1:0]     src_m, gate_m, aux_m, arm_m, a_m, b_m, z_m;
	logic [NCTR-1:0]     src_l_q, gate_l_q, aux_l_q, arm_l_q, a_l_q, b_l_q, z_l_q;
	logic [31:0]         cnt         [NCTR];
	logic [NCTR-1:0]     armed;
	logic [NCTR-1:0]     out_lvl;
	logic [NCTR-1:0]     tc_w;
	logic [3:0]          route_src;

	logic                pready_q;
	logic [31:0]         prdata_q;
	logic                pslverr_q;
	logic                wr_en;
	logic [7:0]          reg_off;
	logic                ctr_idx;
	logic [31:0]         rdata_d;
	logic                err_d;

	assign ext_raw = {GENERATION_SAMPLE_CLOCK, ACQUISITION_CONVERT_CLOCK, ACQUISITION_SAMPLE_CLOCK,
		ACQUISITION_START_TRIGGER, ACQUISITION_REFERENCE_TRIGGER, BACKPLANE_STAR_TRIGGER,
		BACKPLANE_REFERENCE_CLOCK, PROGRAMMABLE_IO_TERMINAL_IN, SYSTEM_TRIGGER_LINE_IN,
		TIMEBASE_100K, TIMEBASE_20M, TIMEBASE_80M};

	// A timebase faster than half the core clock aliases here; only slower sources count true
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= ext_raw;
			sync2_q <= sync1_q;
		end
	end

	// APB slave: no wait state, answer registered in the setup cycle
	assign wr_en   = PSEL & PENABLE & PWRITE & pready_q;
	assign reg_off = {2'b00, PADDR[5:2], 2'b00};
	assign ctr_idx = PADDR[6];

	always_comb begin
		rdata_d = 32'h0000_0000;
		err_d   = 1'b0;
		if (PADDR[7]) begin
			if (PADDR[6]) begin
				err_d = 1'b1;
			end else if ({PADDR[7:2], 2'b00} == cse_pkg::OFF_PIO_ROUTE) begin
				rdata_d = {16'h0000, pio_route_q};
			end else if ({PADDR[7:2], 2'b00} == cse_pkg::OFF_TRIG_ROUTE) begin
				rdata_d = trig_route_q;
			end else begin
				err_d = 1'b1;
			end
		end else begin
			case (reg_off)
				cse_pkg::OFF_CTRL:     rdata_d = {24'h0000_00, ctrl_q[ctr_idx]};
				cse_pkg::OFF_CMD:      rdata_d = 32'h0000_0000;
				cse_pkg::OFF_SEL:      rdata_d = sel_q[ctr_idx];
				cse_pkg::OFF_ENC:      rdata_d = enc_q[ctr_idx];
				cse_pkg::OFF_DELAY:    rdata_d = delay_q[ctr_idx];
				cse_pkg::OFF_WIDTH_HI: rdata_d = whi_q[ctr_idx];
				cse_pkg::OFF_WIDTH_LO: rdata_d = wlo_q[ctr_idx];
				cse_pkg::OFF_INCR:     rdata_d = {24'h0000_00, incr_q[ctr_idx]};
				cse_pkg::OFF_COUNT:    rdata_d = cnt[ctr_idx];
				cse_pkg::OFF_STATUS:   rdata_d = {23'h0000_00, z_l_q[ctr_idx], b_l_q[ctr_idx],
					a_l_q[ctr_idx], aux_l_q[ctr_idx], gate_l_q[ctr_idx], src_l_q[ctr_idx],
					COUNTER_OUT[ctr_idx], TERMINAL_COUNT_FLAG[ctr_idx], armed[ctr_idx]};
				default:               err_d = 1'b1;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= PSEL & ~PENABLE;
			if (PSEL && !PENABLE) begin
				prdata_q  <= PWRITE ? 32'h0000_0000 : rdata_d;
				pslverr_q <= err_d;
			end else begin
				pslverr_q <= 1'b0;
			end
		end
	end

	assign PRDATA  = prdata_q;
	assign PREADY  = pready_q;
	assign PSLVERR = pslverr_q;

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			pio_route_q  <= 16'h0000;
			trig_route_q <= cse_pkg::RST_REG;
		end else if (wr_en && PADDR[7] && !PADDR[6]) begin
			if ({PADDR[7:2], 2'b00} == cse_pkg::OFF_PIO_ROUTE) begin
				pio_route_q <= PWDATA[15:0];
			end
			if ({PADDR[7:2], 2'b00} == cse_pkg::OFF_TRIG_ROUTE) begin
				trig_route_q <= PWDATA;
			end
		end
	end

	genvar c;
	generate
		for (c = 0; c < NCTR; c++) begin : g_ctr
			localparam int O = 1 - c;

			always_ff @(posedge CORE_CLK or posedge RST) begin
				if (RST) begin
					ctrl_q[c]       <= 8'h00;
					sel_q[c]        <= cse_pkg::RST_REG;
					enc_q[c]        <= cse_pkg::RST_REG;
					delay_q[c]      <= cse_pkg::RST_REG;
					whi_q[c]        <= cse_pkg::RST_REG;
					wlo_q[c]        <= cse_pkg::RST_REG;
					incr_q[c]       <= 8'h00;
					arm_cmd_q[c]    <= 1'b0;
					disarm_cmd_q[c] <= 1'b0;
				end else begin
					arm_cmd_q[c]    <= 1'b0;
					disarm_cmd_q[c] <= 1'b0;
					if (wr_en && !PADDR[7] && (ctr_idx == 1'(c))) begin
						case (reg_off)
							cse_pkg::OFF_CTRL:     ctrl_q[c]  <= PWDATA[7:0];
							cse_pkg::OFF_CMD: begin
								arm_cmd_q[c]    <= PWDATA[0];
								disarm_cmd_q[c] <= PWDATA[1];
							end
							cse_pkg::OFF_SEL:      sel_q[c]   <= PWDATA & cse_pkg::SEL_WMASK;
							cse_pkg::OFF_ENC:      enc_q[c]   <= PWDATA & cse_pkg::ENC_WMASK;
							cse_pkg::OFF_DELAY:    delay_q[c] <= PWDATA;
							cse_pkg::OFF_WIDTH_HI: whi_q[c]   <= PWDATA;
							cse_pkg::OFF_WIDTH_LO: wlo_q[c]   <= PWDATA;
							cse_pkg::OFF_INCR:     incr_q[c]  <= PWDATA[7:0];
							default: begin
								arm_cmd_q[c] <= 1'b0;
							end
						endcase
					end
				end
			end

			// Cross routes use registered copies, which breaks gate/source loops
			assign vec[c] = {3'b000, gate_l_q[c], src_l_q[O], COUNTER_OUT[O], gate_l_q[O],
				TERMINAL_COUNT_FLAG[O], sync2_q};

			cse_sel_mux #(.MASK(cse_pkg::MASK_SRC)) u_src (
				.vec(vec[c]), .sel(sel_q[c][4:0]), .lvl(src_m[c]));
			cse_sel_mux #(.MASK(cse_pkg::MASK_GATE)) u_gate (
				.vec(vec[c]), .sel(sel_q[c][12:8]), .lvl(gate_m[c]));
			cse_sel_mux #(.MASK(cse_pkg::MASK_AUX)) u_aux (
				.vec(vec[c]), .sel(sel_q[c][20:16]), .lvl(aux_m[c]));
			cse_sel_mux #(.MASK(cse_pkg::MASK_ARM)) u_arm (
				.vec(vec[c]), .sel(sel_q[c][28:24]), .lvl(arm_m[c]));
			cse_sel_mux #(.MASK(cse_pkg::MASK_ENC)) u_a (
				.vec(vec[c]), .sel(enc_q[c][4:0]), .lvl(a_m[c]));
			cse_sel_mux #(.MASK(cse_pkg::MASK_ENC)) u_b (
				.vec(vec[c]), .sel(enc_q[c][12:8]), .lvl(b_m[c]));
			cse_sel_mux #(.MASK(cse_pkg::MASK_ENC)) u_z (
				.vec(vec[c]), .sel(enc_q[c][20:16]), .lvl(z_m[c]));

			always_ff @(posedge CORE_CLK or posedge RST) begin
				if (RST) begin
					src_l_q[c]  <= 1'b0;
					gate_l_q[c] <= 1'b0;
					aux_l_q[c]  <= 1'b0;
					arm_l_q[c]  <= 1'b0;
					a_l_q[c]    <= 1'b0;
					b_l_q[c]    <= 1'b0;
					z_l_q[c]    <= 1'b0;
				end else begin
					src_l_q[c]  <= src_m[c];
					gate_l_q[c] <= gate_m[c];
					aux_l_q[c]  <= aux_m[c];
					arm_l_q[c]  <= arm_m[c];
					a_l_q[c]    <= a_m[c];
					b_l_q[c]    <= b_m[c];
					z_l_q[c]    <= z_m[c];
				end
			end

			cse_counter #(.CNT_W(cse_pkg::CNT_W), .INCR_W(cse_pkg::INCR_W)) u_counter (
				.clk       (CORE_CLK),
				.rst       (RST),
				.src_lvl   (src_l_q[c]),
				.gate_lvl  (gate_l_q[c]),
				.dir_lvl   (b_l_q[c]),
				.hardware_arm_input_lvl(arm_l_q[c]),
				.arm_cmd   (arm_cmd_q[c]),
				.disarm_cmd(disarm_cmd_q[c]),
				.hardware_arm_input_en (ctrl_q[c][cse_pkg::CTRL_HWARM_EN]),
				.mode      (cse_pkg::cse_mode_type'(ctrl_q[c][1:0])),
				.src_fall  (ctrl_q[c][cse_pkg::CTRL_SRC_FALL]),
				.gate_fall (ctrl_q[c][cse_pkg::CTRL_GATE_FALL]),
				.out_toggle(ctrl_q[c][cse_pkg::CTRL_TOGGLE]),
				.dir_from_b(ctrl_q[c][cse_pkg::CTRL_DIR_B]),
				.delay     (delay_q[c]),
				.width_hi  (whi_q[c]),
				.width_lo  (wlo_q[c]),
				.incr      (incr_q[c]),
				.count_q   (cnt[c]),
				.armed_q   (armed[c]),
				.out_lvl_q (out_lvl[c]),
				.tc        (tc_w[c])
			);

			always_ff @(posedge CORE_CLK or posedge RST) begin
				if (RST) begin
					COUNTER_OUT[c]         <= 1'b0;
					TERMINAL_COUNT_FLAG[c] <= 1'b0;
				end else begin
					COUNTER_OUT[c]         <= out_lvl[c] ^ ctrl_q[c][cse_pkg::CTRL_INVERT];
					TERMINAL_COUNT_FLAG[c] <= tc_w[c];
				end
			end

			logic src_prev_h;
			always_ff @(posedge CORE_CLK or posedge RST) begin
				if (RST) begin
					src_prev_h <= 1'b0;
				end else begin
					src_prev_h <= src_l_q[c];
				end
			end

			tc_zero_a: assert property (@(posedge CORE_CLK) disable iff (RST)
				##1 TERMINAL_COUNT_FLAG[c] == $past(armed[c] && (cnt[c] == 32'h0000_0000)))
				else $error("terminal count flag does not follow zero count");
			arm_hold_a: assert property (@(posedge CORE_CLK) disable iff (RST)
				!armed[c] ##1 !armed[c] |-> $stable(cnt[c]))
				else $error("count moved while disarmed");
			sw_arm_a: assert property (@(posedge CORE_CLK) disable iff (RST)
				arm_cmd_q[c] |=> armed[c])
				else $error("software arm did not arm");
			count_up_a: assert property (@(posedge CORE_CLK) disable iff (RST)
				(armed[c] && ctrl_q[c][1:0] == 2'b00 && src_l_q[c] && !src_prev_h
				&& !ctrl_q[c][cse_pkg::CTRL_SRC_FALL] && !ctrl_q[c][cse_pkg::CTRL_DIR_B])
				|=> cnt[c] == $past(cnt[c]) + 32'h0000_0001)
				else $error("edge count did not increment");
			dir_down_a: assert property (@(posedge CORE_CLK) disable iff (RST)
				(armed[c] && ctrl_q[c][1:0] == 2'b00 && src_l_q[c] && !src_prev_h
				&& !ctrl_q[c][cse_pkg::CTRL_SRC_FALL] && ctrl_q[c][cse_pkg::CTRL_DIR_B] && !b_l_q[c])
				|=> cnt[c] == $past(cnt[c]) - 32'h0000_0001)
				else $error("phase B low did not count down");
			pulse_one_a: assert property (@(posedge CORE_CLK) disable iff (RST)
				(!ctrl_q[c][cse_pkg::CTRL_TOGGLE] && out_lvl[c]) |=> !out_lvl[c])
				else $error("pulse on terminal count wider than one cycle");
			src_legal_a: assert property (@(posedge CORE_CLK) disable iff (RST)
				!cse_pkg::MASK_SRC[sel_q[c][4:0]] |=> !src_l_q[c])
				else $error("illegal source choice passed a signal");
			reset_idle_a: assert property (@(posedge CORE_CLK)
				$past(RST) |-> (cnt[c] == 32'h0000_0000 && !armed[c] && !COUNTER_OUT[c]))
				else $error("counter not idle after reset");
			ets_cov: cover property (@(posedge CORE_CLK) disable iff (RST)
				ctrl_q[c][1:0] == 2'b10 && $rose(out_lvl[c]));
			tc_cov: cover property (@(posedge CORE_CLK) disable iff (RST)
				$rose(TERMINAL_COUNT_FLAG[c]));
		end
	endgenerate

	assign route_src = {gate_l_q[1], src_l_q[1], gate_l_q[0], src_l_q[0]};

	genvar t;
	generate
		for (t = 0; t < 4; t++) begin : g_pio
			always_ff @(posedge CORE_CLK or posedge RST) begin
				if (RST) begin
					PROGRAMMABLE_IO_TERMINAL_OUT[t] <= 1'b0;
					PROGRAMMABLE_IO_TERMINAL_OE[t]  <= 1'b0;
				end else begin
					PROGRAMMABLE_IO_TERMINAL_OUT[t] <= route_src[pio_route_q[4*t +: 2]];
					PROGRAMMABLE_IO_TERMINAL_OE[t]  <= pio_route_q[4*t + cse_pkg::ROUTE_EN];
				end
			end
		end
		for (t = 0; t < 8; t++) begin : g_trig
			always_ff @(posedge CORE_CLK or posedge RST) begin
				if (RST) begin
					SYSTEM_TRIGGER_LINE_OUT[t] <= 1'b0;
					SYSTEM_TRIGGER_LINE_OE[t]  <= 1'b0;
				end else begin
					SYSTEM_TRIGGER_LINE_OUT[t] <= route_src[trig_route_q[4*t +: 2]];
					SYSTEM_TRIGGER_LINE_OE[t]  <= trig_route_q[4*t + cse_pkg::ROUTE_EN];
				end
			end
		end
	endgenerate

	oe_off_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		(pio_route_q == 16'h0000) |=> (PROGRAMMABLE_IO_TERMINAL_OE == 4'h0))
		else $error("terminal driven without a route");
	oe_cov: cover property (@(posedge CORE_CLK) disable iff (RST)
		$rose(PROGRAMMABLE_IO_TERMINAL_OE[0]));
endmodule : cse_routing

// ---- bench/cse_far_model.sv ----
`timescale 1ns/1ps
module cse_far_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       go,
	input  wire logic [7:0] n_edges,
	input  wire logic [3:0] hold,
	output logic            line,
	output logic            busy
);
	logic [7:0] left_q;
	logic [3:0] tick_q;
	assign busy = left_q != 8'h00;
	// Each level held past the input synchroniser, or edges would merge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			left_q <= 8'h00;
			tick_q <= 4'h0;
			line   <= 1'b0;
		end else if (go) begin
			left_q <= n_edges;
			tick_q <= hold;
		end else if (busy) begin
			if (tick_q != 4'h0) begin
				tick_q <= tick_q - 4'h1;
			end else begin
				tick_q <= hold;
				line   <= !line;
				if (line) begin
					left_q <= left_q - 8'h01;
				end
			end
		end
	end
endmodule : cse_far_model

// ---- bench/cse_routing_tb_top.sv ----
`timescale 1ns/1ps
module cse_routing_tb_top;
	logic        clk = 1'b0;
	logic        rst = 1'b0;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [7:0]  pa = 8'h00;
	logic [31:0] pwd = 32'h0000_0000;
	logic [31:0] prd, rd;
	logic        prdy, perr, er;
	logic        go = 1'b0;
	logic [7:0]  ne = 8'h00;
	logic [3:0]  hl = 4'h4;
	logic        line, busy;
	logic [5:0]  pio = 6'h00;
	logic [6:0]  trg = 7'h00;
	logic [7:0]  t_out, t_oe;
	logic [3:0]  p_out, p_oe;
	logic [1:0]  c_out, tcf;
	logic [31:0] seed = 32'h7799_c0d6;
	int          n_fail = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          exp_cnt = 0;
	int          inc = 0;
	initial begin
		forever #4 clk = ~clk;
	end
	cse_far_model far (.clk(clk), .rst(rst), .go(go), .n_edges(ne), .hold(hl), .line(line),
		.busy(busy));
	cse_routing DUT (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
		.TIMEBASE_80M(1'b0), .TIMEBASE_20M(1'b0), .TIMEBASE_100K(1'b0),
		.SYSTEM_TRIGGER_LINE_IN({trg, line}), .SYSTEM_TRIGGER_LINE_OUT(t_out),
		.SYSTEM_TRIGGER_LINE_OE(t_oe), .PROGRAMMABLE_IO_TERMINAL_IN(pio),
		.PROGRAMMABLE_IO_TERMINAL_OUT(p_out), .PROGRAMMABLE_IO_TERMINAL_OE(p_oe),
		.BACKPLANE_REFERENCE_CLOCK(1'b0), .BACKPLANE_STAR_TRIGGER(trg[0]),
		.ACQUISITION_REFERENCE_TRIGGER(trg[1]), .ACQUISITION_START_TRIGGER(trg[2]),
		.ACQUISITION_SAMPLE_CLOCK(trg[3]), .ACQUISITION_CONVERT_CLOCK(trg[4]),
		.GENERATION_SAMPLE_CLOCK(trg[5]), .COUNTER_OUT(c_out), .TERMINAL_COUNT_FLAG(tcf));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic report_and_stop();
		$display("Checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		// Only PREADY or the bench timeout may end this wait
		do begin
			@(posedge clk);
		end while (prdy !== 1'b1);
		rd = prd;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb
	// Random hold makes slow and prompt source edges
	task automatic edges(input int cnt);
		seed = xs(seed);
		ne <= cnt[7:0];
		hl <= 4'h4 + {2'b00, seed[1:0]};
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (2) @(posedge clk);
		while (busy === 1'b1) begin
			@(posedge clk);
		end
		repeat (8) @(posedge clk);
	endtask : edges
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end
	initial begin
		// A real rising edge, so the asynchronous reset acts before the first clock
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("outputs", 32'h0000_0000, {16'h0000, t_oe, p_oe, c_out, tcf});
		apb(1'b0, 8'h28, 32'h0000_0000);
		chk("unmapped_err", 32'h0000_0001, {31'h0, er});
		chk("unmapped_rd", 32'h0000_0000, rd);
		$display("Test reset and map done");
		apb(1'b1, 8'h08, 32'h0000_0003);
		edges(3);
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk("count_unarmed", 32'h0000_0000, rd);
		apb(1'b1, 8'h04, 32'h0000_0001);
		repeat (3) @(posedge clk);
		chk("tc_zero", 32'h0000_0001, {31'h0, tcf[0]});
		seed = xs(seed);
		exp_cnt = 1 + int'(seed[2:0]);
		edges(exp_cnt);
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk("count_up", exp_cnt, rd);
		chk("tc_nonzero", 32'h0000_0000, {31'h0, tcf[0]});
		$display("Test count up done");
		apb(1'b1, 8'h0C, 32'h0000_0C00);
		apb(1'b1, 8'h00, 32'h0000_0040);
		edges(exp_cnt + 1);
		exp_cnt = exp_cnt - (exp_cnt + 1);
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk("count_down", exp_cnt, rd);
		$display("Test count down done");
		pio <= 6'h01;
		apb(1'b1, 8'h48, 32'h0000_000B);
		apb(1'b1, 8'h80, 32'h0000_000A);
		apb(1'b1, 8'h84, 32'h0000_000A);
		repeat (3) @(posedge clk);
		chk("routes", 32'h0000_0311, {22'h0, t_oe[0], t_out[0], 3'h0, p_out[0], p_oe});
		apb(1'b1, 8'h04, 32'h0000_0002);
		apb(1'b0, 8'h24, 32'h0000_0000);
		chk("disarmed", 32'h0000_0000, {31'h0, rd[0]});
		$display("Test route and disarm done");
		// Source and gate share one line, so every delay edge is also an ignored gate edge
		seed = xs(seed);
		inc = int'(seed[1:0]);
		apb(1'b1, 8'h10, 32'h0000_0002);
		apb(1'b1, 8'h14, 32'h0000_0001);
		apb(1'b1, 8'h1C, inc);
		apb(1'b1, 8'h08, 32'h0000_0303);
		apb(1'b1, 8'h00, 32'h0000_0012);
		apb(1'b1, 8'h04, 32'h0000_0001);
		exp_cnt = 2;
		repeat (2) begin
			edges(1 + exp_cnt);
			chk("ets_lead", 32'h0000_0001, {31'h0, c_out[0]});
			edges(1);
			chk("ets_trail", 32'h0000_0000, {31'h0, c_out[0]});
			exp_cnt = exp_cnt + inc;
		end
		$display("Test EQUIVALENT_TIME_SAMPLING_MODE done");
		apb(1'b1, 8'h48, 32'h0000_0003);
		apb(1'b1, 8'h54, 32'h0000_0002);
		apb(1'b1, 8'h58, 32'h0000_0003);
		apb(1'b1, 8'h40, 32'h0000_0011);
		apb(1'b1, 8'h44, 32'h0000_0001);
		edges(1);
		chk("train_hi", 32'h0000_0001, {31'h0, c_out[1]});
		edges(2);
		chk("train_lo", 32'h0000_0000, {31'h0, c_out[1]});
		edges(3);
		chk("train_hi2", 32'h0000_0001, {31'h0, c_out[1]});
		$display("Test pulse train done");
		report_and_stop();
	end
endmodule : cse_routing_tb_top
